// [common/slt_defs.svh]
// constants of the sleep timer: offsets, field positions, reset values
// What this block does
// - direction bit 12: 0 up, 1 down
// - run bit 11: 0 stopped, 1 counting
// - direction, prescale, source writable only while stopped
// - run change lands after two to three ticks
// - freeze bit 10 stops counting during debug halt
// - config resets with only freeze set
// - prescale field 7:4 divides by two to N
// - source bit 0: 0 calibrated, 1 crystal
// - upper read returns 31:16, snapshots lower half
// - lower match write goes to hold only
// - upper match write loads upper and held lower
// - match halves reset to all ones
// - three events: match A, match B, wrap
// - flags B, A, wrap at 2,1,0, write-one-clear
`ifndef SLT_DEFS_SVH
`define SLT_DEFS_SVH
// ============================================================
// register byte addresses
`define SLT_ADDR_CFG    32'h4000_600c
`define SLT_ADDR_CNTU   32'h4000_6010
`define SLT_ADDR_CNTL   32'h4000_6014
`define SLT_ADDR_MAU    32'h4000_6018
`define SLT_ADDR_MAL    32'h4000_601c
`define SLT_ADDR_MBU    32'h4000_6020
`define SLT_ADDR_MBL    32'h4000_6024
`define SLT_ADDR_FLAGS  32'h4000_6028
// ============================================================
// field positions
`define SLT_BIT_DIR     12
`define SLT_BIT_RUN     11
`define SLT_BIT_FREEZE  10
`define SLT_EXP_MSB     7
`define SLT_EXP_LSB     4
`define SLT_BIT_SRC     0
`define SLT_FLAG_B      2
`define SLT_FLAG_A      1
`define SLT_FLAG_WRAP   0
// ============================================================
// reset values, timing and bus answers
`define SLT_CFG_RESET   32'h0000_0400
`define SLT_HALF_RESET  16'hffff
`define SLT_RUN_EDGES   3
`define SLT_RESP_OKAY   2'h0
`define SLT_RESP_SLVERR 2'h2
`endif

// [common/slt_pkg.sv]
// types shared by the sleep timer modules
package slt_pkg;
  // configuration fields as software sees them
  typedef struct packed {
    logic       count_direction;
    logic       timer_run;
    logic       halt_freeze;
    logic [3:0] prescale_exponent;
    logic       tick_source_select;
  } slt_cfg_t;

  // whole state of the tick generator
  typedef struct packed {
    logic        cal_prev;
    logic        crys_prev;
    logic [2:0]  run_pipe;
    logic        active;
    logic [14:0] prescale;
    logic        step;
  } slt_tick_t;

  // whole state of the timer and its bus slave
  typedef struct packed {
    slt_cfg_t    cfg;
    logic [31:0] cnt;
    logic [15:0] snap_lo;
    logic [31:0] match_a;
    logic [31:0] match_b;
    logic [15:0] hold_a;
    logic [15:0] hold_b;
    logic [2:0]  flags;
    logic [2:0]  ev;
    logic        aw_full;
    logic        w_full;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } slt_regs_t;
endpackage : slt_pkg

// [src/slt_tick_gen.sv]
// tick source select, run latency and power-of-two prescaler
`timescale 1ns/1ps
`default_nettype none
`include "slt_defs.svh"
module slt_tick_gen (
  input  wire logic              clk,       // system clock
  input  wire logic              arst_n,    // async reset, low
  input  wire slt_pkg::slt_cfg_t cfg,       // current configuration
  input  wire logic              halt,      // debugger holds cpu
  input  wire logic              cal_tick,  // calibrated slow clock
  input  wire logic              crys_tick, // crystal slow clock
  output var  logic              step,      // one-cycle count pulse
  output var  logic              active     // run seen by counter
);
  slt_pkg::slt_tick_t st_q;
  slt_pkg::slt_tick_t st_d;
  logic               sel_edge;
  logic               frozen;
  logic [14:0]        mask;

  // ============================================================
  // next state
  always_comb begin
    st_d      = st_q;
    // slow clocks are sampled, so a rising edge is one cycle wide
    sel_edge  = cfg.tick_source_select ? (crys_tick & ~st_q.crys_prev)
                                       : (cal_tick & ~st_q.cal_prev);
    frozen    = cfg.halt_freeze & halt;
    mask      = 15'((16'h0001 << cfg.prescale_exponent) - 16'h0001);
    st_d.cal_prev  = cal_tick;
    st_d.crys_prev = crys_tick;
    st_d.step      = 1'b0;
    // three slow edges give a start or stop latency of two to three periods
    if (sel_edge) begin
      st_d.run_pipe = {st_q.run_pipe[1:0], cfg.timer_run};
      st_d.active   = st_q.run_pipe[`SLT_RUN_EDGES-2];
    end
    if (!st_q.active) begin
      st_d.prescale = 15'h0000;
    end else if (sel_edge && !frozen) begin
      st_d.prescale = st_q.prescale + 15'h0001;
      // no step on the edge that stops the timer, so a stopped count never moves
      st_d.step     = st_d.active && ((st_q.prescale & mask) == mask);
    end
    step   = st_q.step;
    active = st_q.active;
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // checks
  AST_HALT_STOPS: assert property (@(posedge clk) disable iff (!arst_n)
    (frozen && st_q.active) |=> !st_q.step)
    else $error("step while frozen by debug halt");
  AST_RUN_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(st_q.active) |-> $past(sel_edge) && $past(st_q.run_pipe[1]) == st_q.active)
    else $error("run change outside a slow edge");
  AST_DIVIDE: assert property (@(posedge clk) disable iff (!arst_n)
    st_q.step |-> $past((st_q.prescale & mask) == mask) && $past(sel_edge))
    else $error("step not at prescaler terminal count");
  COV_START: cover property (@(posedge clk) disable iff (!arst_n) $rose(st_q.active));
endmodule : slt_tick_gen
`default_nettype wire

// [src/slt_top.sv]
// sleep timer: 32-bit counter, match logic and AXI4-Lite registers
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "slt_defs.svh"
module slt_top (
  input  wire logic        CLK,                  // 40 MHz system clock
  input  wire logic        ARST_N,               // async reset, low
  input  wire logic [31:0] S_AXI_AWADDR,         // write address
  input  wire logic        S_AXI_AWVALID,        // write address valid
  output var  logic        S_AXI_AWREADY,        // write address ready
  input  wire logic [31:0] S_AXI_WDATA,          // write data
  input  wire logic [3:0]  S_AXI_WSTRB,          // write byte strobes
  input  wire logic        S_AXI_WVALID,         // write data valid
  output var  logic        S_AXI_WREADY,         // write data ready
  output var  logic [1:0]  S_AXI_BRESP,          // write response
  output var  logic        S_AXI_BVALID,         // write response valid
  input  wire logic        S_AXI_BREADY,         // write response ready
  input  wire logic [31:0] S_AXI_ARADDR,         // read address
  input  wire logic        S_AXI_ARVALID,        // read address valid
  output var  logic        S_AXI_ARREADY,        // read address ready
  output var  logic [31:0] S_AXI_RDATA,          // read data
  output var  logic [1:0]  S_AXI_RRESP,          // read response
  output var  logic        S_AXI_RVALID,         // read data valid
  input  wire logic        S_AXI_RREADY,         // read data ready
  input  wire logic        CALIBRATED_SLOW_TICK, // calibrated 1 kHz clock
  input  wire logic        CRYSTAL_SLOW_TICK,    // 32 kHz crystal clock
  input  wire logic        CPU_HALTED,           // debugger halt level
  output var  logic        MATCH_A_EVENT,        // match A pulse
  output var  logic        MATCH_B_EVENT,        // match B pulse
  output var  logic        WRAP_EVENT,           // wrap pulse
  output var  logic [2:0]  EVENT_FLAGS           // sticky event flags
);
  localparam logic [31:0] CFG_RST_W = `SLT_CFG_RESET;
  localparam logic [31:0] HALF_ONES = {16'h0000, `SLT_HALF_RESET};

  slt_pkg::slt_regs_t st_q;
  slt_pkg::slt_regs_t st_d;
  logic               step;
  logic               run_active;
  logic               wr_go;
  logic               rd_go;
  logic [31:0]        wr_val;
  logic [31:0]        cnt_next;
  logic [2:0]         flag_clr;

  // merge write data into an old word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ============================================================
  // tick generation
  slt_tick_gen i_slt_tick_gen (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .cfg       (st_q.cfg),
    .halt      (CPU_HALTED),
    .cal_tick  (CALIBRATED_SLOW_TICK),
    .crys_tick (CRYSTAL_SLOW_TICK),
    .step      (step),
    .active    (run_active)
  );

  // ============================================================
  // next state: bus slave, registers, counter and events
  always_comb begin
    st_d     = st_q;
    wr_go    = st_q.aw_full & st_q.w_full & ~st_q.bvalid;
    rd_go    = S_AXI_ARVALID & st_q.arready;
    wr_val   = 32'h0000_0000;
    flag_clr = 3'h0;
    cnt_next = st_q.cfg.count_direction ? st_q.cnt - 32'h0000_0001
                                        : st_q.cnt + 32'h0000_0001;

    // address and data are taken in either order and held until used
    if (S_AXI_AWVALID && st_q.awready) begin
      st_d.aw_full = 1'b1;
      st_d.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st_q.wready) begin
      st_d.w_full = 1'b1;
      st_d.wdata  = S_AXI_WDATA;
      st_d.wstrb  = S_AXI_WSTRB;
    end

    // the write takes effect one cycle after both halves are held
    if (wr_go) begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `SLT_RESP_OKAY;
      case (st_q.awaddr)
        `SLT_ADDR_CFG: begin
          wr_val = merge({19'h0, st_q.cfg.count_direction, st_q.cfg.timer_run,
                          st_q.cfg.halt_freeze, 2'h0, st_q.cfg.prescale_exponent,
                          3'h0, st_q.cfg.tick_source_select}, st_q.wdata, st_q.wstrb);
          st_d.cfg.timer_run   = wr_val[`SLT_BIT_RUN];
          st_d.cfg.halt_freeze = wr_val[`SLT_BIT_FREEZE];
          // the mode is kept while the run bit is set; once it clears, mode writes land while the count still runs out its stop latency
          if (!st_q.cfg.timer_run) begin
            st_d.cfg.count_direction    = wr_val[`SLT_BIT_DIR];
            st_d.cfg.prescale_exponent  = wr_val[`SLT_EXP_MSB:`SLT_EXP_LSB];
            st_d.cfg.tick_source_select = wr_val[`SLT_BIT_SRC];
          end
        end
        `SLT_ADDR_CNTU, `SLT_ADDR_CNTL: begin
          st_d.bresp = `SLT_RESP_OKAY;
        end
        `SLT_ADDR_MAU: begin
          wr_val       = merge({16'h0, st_q.match_a[31:16]}, st_q.wdata, st_q.wstrb);
          st_d.match_a = {wr_val[15:0], st_q.hold_a};
        end
        `SLT_ADDR_MAL: begin
          wr_val      = merge({16'h0, st_q.hold_a}, st_q.wdata, st_q.wstrb);
          st_d.hold_a = wr_val[15:0];
        end
        `SLT_ADDR_MBU: begin
          wr_val       = merge({16'h0, st_q.match_b[31:16]}, st_q.wdata, st_q.wstrb);
          st_d.match_b = {wr_val[15:0], st_q.hold_b};
        end
        `SLT_ADDR_MBL: begin
          wr_val      = merge({16'h0, st_q.hold_b}, st_q.wdata, st_q.wstrb);
          st_d.hold_b = wr_val[15:0];
        end
        `SLT_ADDR_FLAGS: begin
          flag_clr = st_q.wdata[2:0] & {3{st_q.wstrb[0]}};
        end
        default: begin
          st_d.bresp = `SLT_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bvalid && S_AXI_BREADY) begin
      st_d.bvalid = 1'b0;
    end
    // one address of each kind is held, so ready drops while it waits
    st_d.awready = ~st_d.aw_full;
    st_d.wready  = ~st_d.w_full;

    // read answers one cycle after the address is taken
    if (rd_go) begin
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rresp   = `SLT_RESP_OKAY;
      st_d.rdata   = 32'h0000_0000;
      case (S_AXI_ARADDR)
        `SLT_ADDR_CFG: begin
          st_d.rdata[`SLT_BIT_DIR]             = st_q.cfg.count_direction;
          st_d.rdata[`SLT_BIT_RUN]             = st_q.cfg.timer_run;
          st_d.rdata[`SLT_BIT_FREEZE]          = st_q.cfg.halt_freeze;
          st_d.rdata[`SLT_EXP_MSB:`SLT_EXP_LSB] = st_q.cfg.prescale_exponent;
          st_d.rdata[`SLT_BIT_SRC]             = st_q.cfg.tick_source_select;
        end
        `SLT_ADDR_CNTU: begin
          // upper and snapshot come from the same cycle, so they agree
          st_d.rdata[15:0] = st_q.cnt[31:16];
          st_d.snap_lo     = st_q.cnt[15:0];
        end
        `SLT_ADDR_CNTL: st_d.rdata[15:0] = st_q.snap_lo;
        `SLT_ADDR_MAU:  st_d.rdata[15:0] = st_q.match_a[31:16];
        `SLT_ADDR_MAL:  st_d.rdata[15:0] = st_q.hold_a;
        `SLT_ADDR_MBU:  st_d.rdata[15:0] = st_q.match_b[31:16];
        `SLT_ADDR_MBL:  st_d.rdata[15:0] = st_q.hold_b;
        `SLT_ADDR_FLAGS: st_d.rdata[2:0] = st_q.flags;
        default: begin
          st_d.rresp = `SLT_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && S_AXI_RREADY) begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end

    // counter steps only on prescaled ticks; wrap either way
    st_d.ev = 3'h0;
    if (step) begin
      st_d.cnt = cnt_next;
      st_d.ev[`SLT_FLAG_WRAP] = st_q.cfg.count_direction ? (st_q.cnt == 32'h0000_0000)
                                                          : (st_q.cnt == 32'hffff_ffff);
      st_d.ev[`SLT_FLAG_A] = (cnt_next == st_q.match_a);
      st_d.ev[`SLT_FLAG_B] = (cnt_next == st_q.match_b);
    end
    // an event in the clearing cycle survives: set wins over clear
    st_d.flags = (st_q.flags & ~flag_clr) | st_d.ev;

    S_AXI_AWREADY = st_q.awready;
    S_AXI_WREADY  = st_q.wready;
    S_AXI_BVALID  = st_q.bvalid;
    S_AXI_BRESP   = st_q.bresp;
    S_AXI_ARREADY = st_q.arready;
    S_AXI_RVALID  = st_q.rvalid;
    S_AXI_RRESP   = st_q.rresp;
    S_AXI_RDATA   = st_q.rdata;
    MATCH_A_EVENT = st_q.ev[`SLT_FLAG_A];
    MATCH_B_EVENT = st_q.ev[`SLT_FLAG_B];
    WRAP_EVENT    = st_q.ev[`SLT_FLAG_WRAP];
    EVENT_FLAGS   = st_q.flags;
  end

  // ============================================================
  // state register with documented reset values
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q         <= '0;
      st_q.cfg     <= '{count_direction:    CFG_RST_W[`SLT_BIT_DIR],
                        timer_run:          CFG_RST_W[`SLT_BIT_RUN],
                        halt_freeze:        CFG_RST_W[`SLT_BIT_FREEZE],
                        prescale_exponent:  CFG_RST_W[`SLT_EXP_MSB:`SLT_EXP_LSB],
                        tick_source_select: CFG_RST_W[`SLT_BIT_SRC]};
      st_q.match_a <= {HALF_ONES[15:0], HALF_ONES[15:0]};
      st_q.match_b <= {HALF_ONES[15:0], HALF_ONES[15:0]};
      st_q.hold_a  <= HALF_ONES[15:0];
      st_q.hold_b  <= HALF_ONES[15:0];
      st_q.awready <= 1'b1;
      st_q.wready  <= 1'b1;
      st_q.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_COUNT_UP: assert property (step && !st_q.cfg.count_direction
    |=> st_q.cnt == $past(st_q.cnt) + 32'h0000_0001)
    else $error("counter did not step up");
  AST_COUNT_DOWN: assert property (step && st_q.cfg.count_direction
    |=> st_q.cnt == $past(st_q.cnt) - 32'h0000_0001)
    else $error("counter did not step down");
  AST_IDLE_HOLD: assert property ((!step || !run_active) |=> $stable(st_q.cnt))
    else $error("counter moved without a tick");
  AST_CFG_LOCK: assert property (wr_go && st_q.awaddr == `SLT_ADDR_CFG
    && st_q.cfg.timer_run |=> $stable(st_q.cfg.count_direction)
    && $stable(st_q.cfg.prescale_exponent) && $stable(st_q.cfg.tick_source_select))
    else $error("mode changed while running");
  AST_SNAPSHOT: assert property (rd_go && S_AXI_ARADDR == `SLT_ADDR_CNTU
    |=> st_q.snap_lo == $past(st_q.cnt[15:0]) && S_AXI_RDATA[15:0] == $past(st_q.cnt[31:16]))
    else $error("upper read did not snapshot the count");
  AST_HOLD_ONLY: assert property (wr_go && st_q.awaddr == `SLT_ADDR_MAL
    |=> $stable(st_q.match_a))
    else $error("lower write changed active match");
  AST_UPPER_LOAD: assert property (wr_go && st_q.awaddr == `SLT_ADDR_MBU
    && st_q.wstrb == 4'hf |=> st_q.match_b == {$past(st_q.wdata[15:0]), $past(st_q.hold_b)})
    else $error("upper write did not load match");
  AST_WRAP_UP: assert property (step && !st_q.cfg.count_direction
    && st_q.cnt == 32'hffff_ffff |=> WRAP_EVENT && st_q.cnt == 32'h0000_0000)
    else $error("wrap not flagged");
  AST_MATCH_A: assert property (MATCH_A_EVENT |-> st_q.cnt == $past(st_q.match_a))
    else $error("match A without equality");
  AST_FLAG_SET: assert property ((st_q.ev & ~EVENT_FLAGS) == 3'h0)
    else $error("event without sticky flag");
  AST_RESERVED: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");

  COV_WRAP: cover property (WRAP_EVENT);
  COV_MATCH_B: cover property (MATCH_B_EVENT);
  COV_UPPER_READ: cover property (rd_go && S_AXI_ARADDR == `SLT_ADDR_CNTU);
  COV_FLAG_CLEAR: cover property (wr_go && st_q.awaddr == `SLT_ADDR_FLAGS);
endmodule : slt_top
`default_nettype wire

// [dv/test_low_power_sleep_timer.sv]
// self-checking bench for the sleep timer registers, counter and events
`timescale 1ns/1ps
`default_nettype none
`include "slt_defs.svh"
module test_low_power_sleep_timer;
  // ============================================================
  // stimulus and observation signals
  localparam int cal_half  = 8; // calibrated tick half period in clk cycles
  localparam int crys_half = 2; // crystal tick half period in clk cycles
  logic        clk     = 1'h0;
  logic        arst_n  = 1'h0;
  logic [31:0] awaddr  = 32'h0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] araddr  = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic        cal     = 1'h0;
  logic        crys    = 1'h0;
  logic        halted  = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, ev_a, ev_b, ev_w;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, v, w, c, pa;
  logic [2:0]  flags;
  int          miscompares = 0;
  int          checks      = 0;
  int          cyc         = 0;
  int          wraps       = 0; // wrap pulses seen since time zero
  int          t0, t1;
  // reset values of every mapped register, the flag register last
  logic [31:0] rst_addr [8] = '{`SLT_ADDR_CFG, `SLT_ADDR_CNTU, `SLT_ADDR_CNTL, `SLT_ADDR_MAU,
                                `SLT_ADDR_MAL, `SLT_ADDR_MBU, `SLT_ADDR_MBL, `SLT_ADDR_FLAGS};
  logic [31:0] rst_val  [8] = '{`SLT_CFG_RESET, 32'h0, 32'h0, 32'hffff, 32'hffff, 32'hffff,
                                32'hffff, 32'h0};
  // timing rows: direction, prescale exponent and source, run bit clear
  logic [31:0] row_cfg  [5] = '{32'h1000, 32'h0031, 32'h0020, 32'h1091, 32'h1001};

  slt_top i_slt_top (
    .CLK(clk), .ARST_N(arst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CALIBRATED_SLOW_TICK(cal), .CRYSTAL_SLOW_TICK(crys), .CPU_HALTED(halted),
    .MATCH_A_EVENT(ev_a), .MATCH_B_EVENT(ev_b), .WRAP_EVENT(ev_w), .EVENT_FLAGS(flags)
  );

  // ============================================================
  // clocks; the slow ticks run far faster than real so the run stays short
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    forever begin
      repeat (cal_half) @(posedge clk);
      cal <= ~cal;
    end
  end
  initial begin
    forever begin
      repeat (crys_half) @(posedge clk);
      crys <= ~crys;
    end
  end
  // cycle count and wrap pulses; an unknown before reset is never counted
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ev_w === 1'h1) begin
      wraps <= wraps + 1;
    end
  end
  // watchdog sized well above the longest row
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    conclude();
  end

  // ============================================================
  // bus tasks; ready and valid are sampled at the falling edge so the
  // release at the next rising edge never races the slave's update
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, ha, hw, hb;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge clk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      ta = ta | ha;
      tw = tw | hw;
    end
    do begin
      @(negedge clk);
      hb = bvalid;
      if (hb) chk({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
    end while (!hb);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
    logic hit;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      hit = arready;
      @(posedge clk);
    end while (!hit);
    arvalid <= 1'h0;
    do begin
      @(negedge clk);
      hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!hit);
    rready <= 1'h0;
    chk({30'h0, r}, {30'h0, er});
  endtask : rd

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, `SLT_RESP_OKAY);
    chk(d, exp);
  endtask : rdc

  // upper half first so the lower half is the snapshot taken with it
  task automatic cnt(output logic [31:0] val);
    logic [31:0] u, l;
    rd(`SLT_ADDR_CNTU, u, `SLT_RESP_OKAY);
    rd(`SLT_ADDR_CNTL, l, `SLT_RESP_OKAY);
    val = {u[15:0], l[15:0]};
  endtask : cnt

  task automatic wait_ev(input logic b, output int t);
    do begin
      @(posedge clk);
      #1;
    end while (!(b ? ev_b : ev_a));
    t = cyc;
  endtask : wait_ev

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // ============================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      rdc(rst_addr[i], rst_val[i]);
    end
    rd(32'h4000_6030, v, `SLT_RESP_SLVERR);
    chk(v, 32'h0);
    wr(32'h4000_6030, 32'hffff_ffff, `SLT_RESP_SLVERR);
    wr(`SLT_ADDR_CNTU, 32'hffff_ffff, `SLT_RESP_OKAY);
    rdc(`SLT_ADDR_CNTU, 32'h0);
    // reserved bits stay zero; a running timer ignores all but run and freeze
    wr(`SLT_ADDR_CFG, 32'hffff_ffff, `SLT_RESP_OKAY);
    rdc(`SLT_ADDR_CFG, 32'h1cf1);
    wr(`SLT_ADDR_CFG, 32'h0800, `SLT_RESP_OKAY);
    rdc(`SLT_ADDR_CFG, 32'h18f1);
    wr(`SLT_ADDR_CFG, 32'h0, `SLT_RESP_OKAY);
    repeat (100) @(posedge clk);
    // halt held high with freeze clear: counting must go on regardless
    halted <= 1'h1;
    pa = 32'hffff;
    for (int i = 0; i < 5; i++) begin
      c = row_cfg[i];
      wr(`SLT_ADDR_CFG, c, `SLT_RESP_OKAY);
      cnt(v);
      w = c[12] ? v - 32'h2 : v + 32'h2;
      // match values change only while stopped
      wr(`SLT_ADDR_MAL, {16'h0, w[15:0]}, `SLT_RESP_OKAY);
      rdc(`SLT_ADDR_MAU, pa);
      rdc(`SLT_ADDR_MAL, {16'h0, w[15:0]});
      wr(`SLT_ADDR_MAU, {16'h0, w[31:16]}, `SLT_RESP_OKAY);
      pa = {16'h0, w[31:16]};
      w = c[12] ? v - 32'h3 : v + 32'h3;
      wr(`SLT_ADDR_MBL, {16'h0, w[15:0]}, `SLT_RESP_OKAY);
      wr(`SLT_ADDR_MBU, {16'h0, w[31:16]}, `SLT_RESP_OKAY);
      rdc(`SLT_ADDR_MBU, {16'h0, w[31:16]});
      rdc(`SLT_ADDR_MBL, {16'h0, w[15:0]});
      wr(`SLT_ADDR_CFG, c | 32'h0800, `SLT_RESP_OKAY);
      rdc(`SLT_ADDR_CFG, c | 32'h0800);
      wait_ev(1'h0, t0);
      wait_ev(1'h1, t1);
      chk(32'(t1 - t0), 32'((c[0] ? 2 * crys_half : 2 * cal_half) << c[7:4]));
      wr(`SLT_ADDR_CFG, c, `SLT_RESP_OKAY);
      repeat (300) @(posedge clk);
      if (i == 0) begin
        chk({29'h0, flags}, 32'h7);
        chk(32'(wraps), 32'h1);
        wr(`SLT_ADDR_FLAGS, 32'h7, `SLT_RESP_OKAY);
        rdc(`SLT_ADDR_FLAGS, 32'h0);
      end
    end
    // freeze set and halted: the count must hold, then move once released
    wr(`SLT_ADDR_CFG, 32'h0c00, `SLT_RESP_OKAY);
    repeat (200) @(posedge clk);
    cnt(v);
    repeat (300) @(posedge clk);
    cnt(w);
    chk(w, v);
    halted <= 1'h0;
    repeat (300) @(posedge clk);
    cnt(w);
    chk({31'h0, w != v}, 32'h1);
    wr(`SLT_ADDR_CFG, 32'h0, `SLT_RESP_OKAY);
    // second reset while the counter is still winding down
    arst_n <= 1'h0;
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      rdc(rst_addr[i], rst_val[i]);
    end
    chk({29'h0, flags}, 32'h0);
    conclude();
  end
endmodule : test_low_power_sleep_timer
`default_nettype wire
